/* hdl/dwicd_pkg.sv */
/*
 * constants for the dual wiper command decoder: opcodes, field positions,
 * reset values and timing counts.
 * assumes a 40 MHz system clock.
 */
package dwicd_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned WIPER_W       = 6;
    localparam int unsigned TAPS          = 64;
    localparam int unsigned NUM_POTS      = 2;
    localparam int unsigned NUM_SETTINGS  = 4;
    // device type code; value is arbitrary
    localparam logic [3:0]  DEV_TYPE_CODE = 4'h9;
    // instruction byte field positions
    localparam int unsigned OPC_MSB       = 7;
    localparam int unsigned OPC_LSB       = 4;
    localparam int unsigned RSVD_BIT      = 3;
    localparam int unsigned POT_BIT       = 2;
    localparam int unsigned SEL_MSB       = 1;
    localparam int unsigned SEL_LSB       = 0;
    // opcodes
    localparam logic [3:0]  OPC_RD_WIPER  = 4'h9;
    localparam logic [3:0]  OPC_WR_WIPER  = 4'hA;
    localparam logic [3:0]  OPC_RD_SET    = 4'hB;
    localparam logic [3:0]  OPC_WR_SET    = 4'hC;
    localparam logic [3:0]  OPC_XFR_S2W   = 4'hD;
    localparam logic [3:0]  OPC_XFR_W2S   = 4'hE;
    localparam logic [3:0]  OPC_GXFR_S2W  = 4'h1;
    localparam logic [3:0]  OPC_GXFR_W2S  = 4'h8;
    localparam logic [3:0]  OPC_INCDEC    = 4'h2;
    // reset contents of the stored settings, and the wiper step limits
    localparam logic [5:0]  SETTING_RST   = 6'h20;
    localparam logic [5:0]  WIPER_MAX     = 6'h3F;
    localparam logic [5:0]  WIPER_MIN     = 6'h00;
    // timing
    localparam int unsigned NV_WRITE_MS   = 5;
    localparam int unsigned NV_WRITE_CYC  = (CLK_HZ / 1000) * NV_WRITE_MS;
    localparam int unsigned WRL_NS        = 100;
    localparam int unsigned WRL_CYC       = (WRL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [2:0] {
        DWICD_IDLE, DWICD_ADDR, DWICD_INSTR, DWICD_DATA, DWICD_READ,
        DWICD_INCDEC, DWICD_WAIT_STOP
    } dwicd_state_e;
endpackage : dwicd_pkg

/* hdl/dwicd_core.sv */
/*
 * i2c slave command decoder with wiper and stored setting registers for a
 * dual 64 tap potentiometer.
 * assumes scl and sda come from pins (synchronised here), sda drive is
 * open drain resolved outside, address pins are static straps.
 */
`timescale 1ns/100ps

// Contract
// [R1] upper address nibble must equal type code
// [R2] lower address nibble must match pins
// [R3] busy nv write withholds address acknowledge
// [R4] master polls address until acknowledged
// [R5] instruction: opcode, pot bit, setting bits
// [R6] setting bits pick one of four
// [R7] two wipers, one-hot 64 tap decode
// [R8] reset loads wipers from first setting
// [R9] four stored settings per pot
// [R10] setting change busy at most 5 ms
// [R11] read wiper returns third byte
// [R12] write wiper loads after response delay
// [R13] read/write setting by pot and select
// [R14] setting to wiper single transfer
// [R15] wiper to setting single transfer
// [R16] global setting to wiper transfer
// [R17] global wiper to setting transfer
// [R18] three-byte reads/writes, two-byte transfers
// [R19] sda high scl pulse steps up
// [R20] sda low scl pulse steps down
// [R21] master steps freely, ends with stop
// [R22] read setting opcode 1011
// [R23] write setting opcode 1100, nv write
// [R24] setting to wiper opcode 1101
// [R25] read wiper 1001, write wiper 1010
// [R26] reserved bit zero, unknown opcodes ignored
// [R27] steps saturate at tap 0 and 63
module dwicd_core
    import dwicd_pkg::*;
#(
    parameter int unsigned NV_CYCLES = NV_WRITE_CYC  // nv write busy length
) (
    input  wire logic                clk,         // system clock
    input  wire logic                sys_rst,     // sync reset, high
    input  wire logic                scl_in,      // i2c clock pin
    input  wire logic                sda_in,      // i2c data pin level
    output logic                     sda_out,     // sda drive value
    output logic                     sda_oe,      // sda drive enable
    input  wire logic [3:0]          pin_address_bits, // address straps
    output logic [TAPS-1:0]          tap0,        // pot 0 tap switches
    output logic [TAPS-1:0]          tap1,        // pot 1 tap switches
    output logic [WIPER_W-1:0]       wiper0,      // pot 0 wiper register
    output logic [WIPER_W-1:0]       wiper1,      // pot 1 wiper register
    output logic                     nv_busy      // nv write in progress
);
    import dwicd_pkg::*;

    // tap decode of a wiper value
    function automatic logic [TAPS-1:0] tap_decode(input logic [WIPER_W-1:0] w);
        logic [TAPS-1:0] t;
        t = '0;
        t[w] = 1'b1;
        return t;
    endfunction : tap_decode

    // saturating step
    function automatic logic [WIPER_W-1:0] step(input logic [WIPER_W-1:0] w,
                                               input logic up);
        logic [WIPER_W-1:0] r;
        r = w;
        if (up && w != WIPER_MAX) begin
            r = w + 6'h01;
        end else if (!up && w != WIPER_MIN) begin
            r = w - 6'h01;
        end
        return r;
    endfunction : step

    logic [2:0]            scl_s;
    logic [2:0]            sda_s;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_det;
    logic                  stop_det;
    dwicd_state_e          state;
    logic [7:0]            shreg;
    logic [3:0]            bitcnt;
    logic                  ack_phase;
    logic [7:0]            instr;
    logic                  rd_dir;
    logic [WIPER_W-1:0]    wiper_position_reg [NUM_POTS];
    logic [WIPER_W-1:0]    stored_setting_reg [NUM_POTS][NUM_SETTINGS];
    logic [WIPER_W-1:0]    wr_pending_val;
    logic [1:0]            wr_pending_pot;
    logic                  wr_pending;
    logic [7:0]            wrl_cnt;
    logic                  nv_arm;
    logic [31:0]           nv_cnt;
    logic                  step_valid;

    // two flops, then a third for edge finding
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_s <= 3'b111;
            sda_s <= 3'b111;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
        end
    end

    // address straps pass two flops like any other pin
    logic [3:0]            addr_sync1;
    logic [3:0]            addr_sync2;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_sync1 <= 4'h0;
            addr_sync2 <= 4'h0;
        end else begin
            addr_sync1 <= pin_address_bits;
            addr_sync2 <= addr_sync1;
        end
    end

    assign scl_rise  = scl_s[1] & ~scl_s[2];
    assign scl_fall  = ~scl_s[1] & scl_s[2];
    assign start_det = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    assign stop_det  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

    // decoded instruction fields
    logic [3:0] opc;
    logic       psel;
    logic [1:0] ssel;
    logic       rsvd_ok;
    assign opc     = instr[OPC_MSB:OPC_LSB];              // [R5]
    assign psel    = instr[POT_BIT];                      // [R5]
    assign ssel    = instr[SEL_MSB:SEL_LSB];              // [R5] [R6]
    assign rsvd_ok = ~instr[RSVD_BIT];                    // [R26]

    // protocol state machine and byte shifter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state      <= DWICD_IDLE;
            shreg      <= 8'h00;
            bitcnt     <= 4'h0;
            ack_phase  <= 1'b0;
            instr      <= 8'h00;
            rd_dir     <= 1'b0;
            sda_out    <= 1'b1;
            sda_oe     <= 1'b0;
            step_valid <= 1'b0;
        end else begin
            step_valid <= 1'b0;
            if (start_det) begin
                state     <= DWICD_ADDR;
                bitcnt    <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe    <= 1'b0;
            end else if (stop_det) begin
                state  <= DWICD_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    DWICD_IDLE, DWICD_WAIT_STOP: begin
                        sda_oe <= 1'b0;
                    end
                    DWICD_ADDR, DWICD_INSTR, DWICD_DATA: begin
                        if (scl_rise && !ack_phase) begin
                            shreg  <= {shreg[6:0], sda_s[1]};
                            bitcnt <= bitcnt + 4'h1;
                        end
                        if (scl_fall && !ack_phase && bitcnt == 4'h8) begin
                            ack_phase <= 1'b1;
                            bitcnt    <= 4'h0;
                            sda_out   <= 1'b0;
                            if (state == DWICD_ADDR) begin
                                // [R1] [R2] address match, [R3] [R4] busy withholds ack
                                sda_oe <= (shreg[7:4] == DEV_TYPE_CODE) &&
                                          (shreg[3:0] == addr_sync2) && !nv_busy;
                                if (!((shreg[7:4] == DEV_TYPE_CODE) &&
                                      (shreg[3:0] == addr_sync2) && !nv_busy)) begin
                                    state <= DWICD_WAIT_STOP;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                if (state == DWICD_INSTR) begin
                                    instr <= shreg;
                                end
                            end
                        end else if (scl_fall && ack_phase) begin
                            ack_phase <= 1'b0;
                            sda_oe    <= 1'b0;
                            case (state)
                                DWICD_ADDR: begin
                                    state <= DWICD_INSTR;
                                end
                                DWICD_INSTR: begin
                                    // [R18] reads transmit a third byte
                                    if (instr[OPC_MSB:OPC_LSB] == OPC_RD_WIPER ||
                                        instr[OPC_MSB:OPC_LSB] == OPC_RD_SET) begin
                                        state  <= DWICD_READ;
                                        rd_dir <= 1'b1;
                                        // byte bit 7 is zero and goes out now, rest on falls
                                        shreg  <= {1'b0, ((instr[OPC_MSB:OPC_LSB] ==
                                            OPC_RD_WIPER) ? wiper_position_reg[instr[POT_BIT]]
                                            : stored_setting_reg[instr[POT_BIT]]
                                              [instr[SEL_MSB:SEL_LSB]]), 1'b0}; // [R11] [R13] [R22]
                                        bitcnt  <= 4'h1;
                                        sda_out <= 1'b0;
                                        sda_oe  <= 1'b1;
                                    end else if (instr[OPC_MSB:OPC_LSB] == OPC_INCDEC) begin
                                        state <= DWICD_INCDEC;
                                    end else begin
                                        state <= DWICD_DATA;
                                    end
                                end
                                default: begin
                                    state <= DWICD_WAIT_STOP;
                                end
                            endcase
                        end
                    end
                    DWICD_READ: begin
                        // shift out msb first, release for master ack
                        if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                sda_oe <= 1'b0;
                                bitcnt <= 4'h9;
                            end else if (bitcnt == 4'h9) begin
                                state <= DWICD_WAIT_STOP;
                            end else begin
                                sda_out <= shreg[7];
                                sda_oe  <= ~shreg[7];
                                shreg   <= {shreg[6:0], 1'b0};
                                bitcnt  <= bitcnt + 4'h1;
                            end
                        end
                    end
                    DWICD_INCDEC: begin
                        // each scl high pulse is one step
                        if (scl_rise) begin
                            step_valid <= 1'b1;               // [R19] [R20] [R21]
                        end
                    end
                    default: begin
                        state <= DWICD_IDLE;
                    end
                endcase
            end
        end
    end

    // completed data byte
    logic data_done;
    assign data_done = (state == DWICD_DATA) && scl_fall && ack_phase;

    // transfer instructions complete on the ack of the instruction byte
    logic nv_arm_go;
    assign nv_arm_go = (state == DWICD_INSTR) && scl_fall && ack_phase;   // [R18]

    // wiper registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // [R8] wipers start from the first stored setting
            for (int p = 0; p < NUM_POTS; p++) begin
                wiper_position_reg[p] <= SETTING_RST;
            end
            wr_pending     <= 1'b0;
            wr_pending_val <= '0;
            wr_pending_pot <= 2'b00;
            wrl_cnt        <= 8'h00;
        end else begin
            if (data_done && opc == OPC_WR_WIPER && rsvd_ok) begin
                // [R12] [R25] write wiper after response delay
                wr_pending     <= 1'b1;
                wr_pending_val <= shreg[WIPER_W-1:0];
                wr_pending_pot <= {1'b0, psel};
                wrl_cnt        <= WRL_CYC[7:0];
            end else if (wr_pending) begin
                if (wrl_cnt <= 8'h01) begin
                    wr_pending <= 1'b0;
                    wiper_position_reg[wr_pending_pot[0]] <= wr_pending_val;
                end else begin
                    wrl_cnt <= wrl_cnt - 8'h01;
                end
            end
            if (state == DWICD_INCDEC && step_valid) begin
                // [R19] [R20] [R27] saturating step
                wiper_position_reg[psel] <= step(wiper_position_reg[psel], sda_s[2]);
            end
            if (nv_arm_go && rsvd_ok) begin
                if (opc == OPC_XFR_S2W) begin
                    // [R14] [R24]
                    wiper_position_reg[psel] <= stored_setting_reg[psel][ssel];
                end else if (opc == OPC_GXFR_S2W && !psel) begin
                    // [R16]
                    for (int p = 0; p < NUM_POTS; p++) begin
                        wiper_position_reg[p] <= stored_setting_reg[p][ssel];
                    end
                end
            end
        end
    end

    // stored settings and the nv write timer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int p = 0; p < NUM_POTS; p++) begin
                for (int s = 0; s < NUM_SETTINGS; s++) begin
                    stored_setting_reg[p][s] <= SETTING_RST;              // [R9]
                end
            end
            nv_arm  <= 1'b0;
            nv_cnt  <= '0;
            nv_busy <= 1'b0;
        end else begin
            if (data_done && opc == OPC_WR_SET && rsvd_ok) begin
                stored_setting_reg[psel][ssel] <= shreg[WIPER_W-1:0];   // [R13] [R23]
                nv_arm <= 1'b1;
            end
            if (nv_arm_go && rsvd_ok && opc == OPC_XFR_W2S) begin
                stored_setting_reg[psel][ssel] <= wiper_position_reg[psel]; // [R15]
                nv_arm <= 1'b1;
            end
            if (nv_arm_go && rsvd_ok && opc == OPC_GXFR_W2S && !psel) begin
                for (int p = 0; p < NUM_POTS; p++) begin
                    stored_setting_reg[p][ssel] <= wiper_position_reg[p]; // [R17]
                end
                nv_arm <= 1'b1;
            end
            // [R3] [R10] busy starts at stop, lasts the write cycle
            if (stop_det && nv_arm) begin
                nv_arm  <= 1'b0;
                nv_busy <= 1'b1;
                nv_cnt  <= NV_CYCLES - 1;
            end else if (start_det && nv_arm) begin
                nv_arm <= 1'b0;
            end else if (nv_busy) begin
                if (nv_cnt == 0) begin
                    nv_busy <= 1'b0;
                end else begin
                    nv_cnt <= nv_cnt - 1;
                end
            end
        end
    end

    // registered outputs and tap decode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wiper0 <= SETTING_RST;
            wiper1 <= SETTING_RST;
            tap0   <= tap_decode(SETTING_RST);
            tap1   <= tap_decode(SETTING_RST);
        end else begin
            wiper0 <= wiper_position_reg[0];
            wiper1 <= wiper_position_reg[1];
            tap0   <= tap_decode(wiper_position_reg[0]);             // [R7]
            tap1   <= tap_decode(wiper_position_reg[1]);             // [R7]
        end
    end
endmodule : dwicd_core

/* verif/dwicd_checker.sv */
/*
 * port assertions for the dual wiper command decoder.
 * assumes it is bound into dwicd_core and runs on its 40 MHz clock.
 */
`timescale 1ns/100ps
module dwicd_checker
    import dwicd_pkg::*;
#(
    parameter int unsigned NV_CYCLES = NV_WRITE_CYC  // nv busy length
) (
    input wire logic               clk,              // system clock
    input wire logic               sys_rst,          // sync reset, high
    input wire logic               scl_in,           // bus clock pin
    input wire logic               sda_in,           // bus data level
    input wire logic               sda_out,          // sda drive value
    input wire logic               sda_oe,           // sda drive enable
    input wire logic [3:0]         pin_address_bits, // address straps
    input wire logic [TAPS-1:0]    tap0,             // pot 0 taps
    input wire logic [TAPS-1:0]    tap1,             // pot 1 taps
    input wire logic [WIPER_W-1:0] wiper0,           // pot 0 wiper
    input wire logic [WIPER_W-1:0] wiper1,           // pot 1 wiper
    input wire logic               nv_busy           // nv write busy
);
    int unsigned busy_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // length of the current nv busy spell
    always_ff @(posedge clk) begin
        if (sys_rst || !nv_busy) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    // bus idle after a stop, wipers settled
    sequence s_bus_stop;
        scl_in && sda_in;
    endsequence
    sequence s_calm0;
        $stable(wiper0) [*3];
    endsequence
    sequence s_calm1;
        $stable(wiper1) [*3];
    endsequence

    a_tap0_decode: assert property (s_calm0 |-> tap0 == (64'h1 << wiper0))
        else $error("pot 0 taps disagree with wiper");
    a_tap1_decode: assert property (s_calm1 |-> tap1 == (64'h1 << wiper1))
        else $error("pot 1 taps disagree with wiper");
    a_taps_onehot: assert property ($onehot(tap0) && $onehot(tap1))
        else $error("tap select not one-hot");
    a_reset_load: assert property ($fell(sys_rst) |-> wiper0 == SETTING_RST && wiper1 == SETTING_RST)
        else $error("wipers not loaded from first setting");
    a_busy_length: assert property ($fell(nv_busy) |-> busy_cnt inside {[NV_CYCLES-1:NV_CYCLES+1]})
        else $error("nv busy length wrong");
    a_busy_no_ack: assert property (nv_busy |-> !sda_oe)
        else $error("device drives sda while busy");
    a_busy_at_stop: assert property ($rose(nv_busy) |-> s_bus_stop)
        else $error("nv busy began outside a stop");
    a_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_in && !sda_out)
        else $error("sda driven while scl high");
endmodule : dwicd_checker

bind dwicd_core dwicd_checker #(.NV_CYCLES(NV_CYCLES)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .pin_address_bits(pin_address_bits), .tap0(tap0), .tap1(tap1),
    .wiper0(wiper0), .wiper1(wiper1), .nv_busy(nv_busy));

/* verif/dwicd_i2c_master.sv */
/*
 * bus master model: start, stop, bit, byte and ack polling tasks.
 * assumes an open drain sda resolved by the bench; scl period 200 ns.
 */
`timescale 1ns/100ps
module dwicd_i2c_master (
    output logic      scl,      // bus clock, idles high
    output logic      sda,      // master sda, 1 releases
    input  wire logic sda_line  // resolved sda level
);
    // bus idles released, clock still outside frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // start or repeated start
    task automatic start;
        sda = 1'b1;
        #50 scl = 1'b1;
        #100 sda = 1'b0;
        #100 scl = 1'b0;
    endtask : start
    task automatic stop;
        #50 sda = 1'b0;
        #50 scl = 1'b1;
        #100 sda = 1'b1;
        #100;
    endtask : stop
    // one clock pulse, data set mid low phase
    task automatic xbit(input logic b, output logic r);
        #50 sda = b;
        #50 scl = 1'b1;
        #50 r = sda_line;
        #50 scl = 1'b0;
    endtask : xbit
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask : wbyte
    // read a byte and answer with no acknowledge
    task automatic rbyte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(1'b1, r);
    endtask : rbyte
    // repeat address until acknowledged, bounded
    task automatic poll(input logic [7:0] a, output int n);
        logic ok;
        n = 0;
        ok = 1'b0;
        while (!ok && n < 50) begin
            n++;
            start();
            wbyte(a, ok);
            stop();
        end
    endtask : poll
endmodule : dwicd_i2c_master

/* verif/dual_wiper_i2c_command_decoder_tb_top.sv */
/*
 * self-checking bench: integer reference model against the decoder.
 * assumes dwicd_core, its checker and the master model are compiled.
 */
`timescale 1ns/100ps
module dual_wiper_i2c_command_decoder_tb_top;
    import dwicd_pkg::*;
    localparam int unsigned NVC = 200;  // shortened nv write
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  pins = 4'h0;
    logic        scl, m_sda, sda_out, sda_oe, nv_busy, ack;
    logic [63:0] tap0, tap1;
    logic [5:0]  wiper0, wiper1;
    logic [7:0]  adr, d;
    wire         sda_line = m_sda & ~(sda_oe & ~sda_out);
    int          err_count = 0;
    int          compares = 0;
    int          wip [2];
    int          st [2][4];
    int          n, p, r, q;

    always #12.5 clk = ~clk;

    dwicd_core #(.NV_CYCLES(NVC)) dut (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .pin_address_bits(pins), .tap0(tap0), .tap1(tap1),
        .wiper0(wiper0), .wiper1(wiper1), .nv_busy(nv_busy));
    dwicd_i2c_master mst (.scl(scl), .sda(m_sda), .sda_line(sda_line));

    task automatic give_verdict;
        if (err_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_wip;
        chk("wiper0", 64'(wip[0]), 64'(wiper0));
        chk("wiper1", 64'(wip[1]), 64'(wiper1));
        chk("tap0", 64'h1 << wip[0], tap0);
        chk("tap1", 64'h1 << wip[1], tap1);
    endtask : chk_wip
    // full command; nv ones are polled out
    task automatic cmd(input logic [7:0] ins, input bit dat_on, input logic [7:0] dat,
                       input bit nv);
        mst.start();
        mst.wbyte(adr, ack);
        chk("addr_ack", 64'h1, 64'(ack));
        mst.wbyte(ins, ack);
        chk("instr_ack", 64'h1, 64'(ack));
        if (dat_on) begin
            mst.wbyte(dat, ack);
            chk("data_ack", 64'h1, 64'(ack));
        end
        mst.stop();
        chk("nv_busy", 64'(nv), 64'(nv_busy));
        if (nv) begin
            mst.poll(adr, n);
            chk("poll_count", 64'h1, 64'(n > 1 && n < 50));
        end
        chk_wip();
    endtask : cmd
    task automatic rd(input logic [7:0] ins, input int e);
        mst.start();
        mst.wbyte(adr, ack);
        mst.wbyte(ins, ack);
        mst.rbyte(d);
        mst.stop();
        chk("read_byte", 64'(e), 64'(d));
    endtask : rd

    // hang guard
    initial begin
        #2_000_000;
        err_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'h2691ba56));
        for (int i = 0; i < 8; i++) st[i/4][i%4] = 32;
        wip = '{32, 32};
        pins = 4'($urandom);
        adr = {DEV_TYPE_CODE, pins};
        repeat (4) @(posedge clk);
        #2 sys_rst = 1'b0;
        repeat (4) @(posedge clk);
        chk_wip();
        // foreign type code, then foreign pin address
        for (int i = 0; i < 2; i++) begin
            mst.start();
            mst.wbyte(i == 0 ? {~DEV_TYPE_CODE, pins} : {DEV_TYPE_CODE, ~pins}, ack);
            mst.stop();
            chk("foreign_ack", 64'h0, 64'(ack));
        end
        for (p = 0; p < 2; p++) begin
            q = $urandom_range(63);
            wip[p] = q;
            cmd({OPC_WR_WIPER, 1'b0, 1'(p), 2'b00}, 1, 8'(q), 0);
            rd({OPC_RD_WIPER, 1'b0, 1'(p), 2'b00}, q);
        end
        for (int i = 0; i < 8; i++) begin
            q = $urandom_range(63);
            st[i/4][i%4] = q;
            cmd({OPC_WR_SET, 1'b0, 1'(i/4), 2'(i%4)}, 1, 8'(q), 1);
            rd({OPC_RD_SET, 1'b0, 1'(i/4), 2'(i%4)}, q);
        end
        p = $urandom_range(1);
        r = $urandom_range(3);
        wip[p] = st[p][r];
        cmd({OPC_XFR_S2W, 1'b0, 1'(p), 2'(r)}, 0, 8'h00, 0);
        r = (r + 1) % 4;
        st[p][r] = wip[p];
        cmd({OPC_XFR_W2S, 1'b0, 1'(p), 2'(r)}, 0, 8'h00, 1);
        r = $urandom_range(3);
        wip[0] = st[0][r];
        wip[1] = st[1][r];
        cmd({OPC_GXFR_S2W, 4'(r)}, 0, 8'h00, 0);
        r = (r + 1) % 4;
        st[0][r] = wip[0];
        st[1][r] = wip[1];
        cmd({OPC_GXFR_W2S, 4'(r)}, 0, 8'h00, 1);
        // reserved bit set, then an unknown opcode: nothing moves
        cmd({OPC_WR_WIPER, 4'h8}, 1, 8'h15, 0);
        cmd(8'h00, 0, 8'h00, 0);
        for (int i = 0; i < 8; i++) rd({OPC_RD_SET, 1'b0, 1'(i/4), 2'(i%4)}, st[i/4][i%4]);
        // steps on pot 1: up to the top, a mix, then down past the bottom
        mst.start();
        mst.wbyte(adr, ack);
        mst.wbyte({OPC_INCDEC, 4'h4}, ack);
        for (int i = 0; i < 140; i++) begin
            mst.xbit(i < 64 || i == 66, ack);
            if (i == 63 || i == 66) begin
                #400;
                chk("step_wiper1", i == 63 ? 64'd63 : 64'd62, 64'(wiper1));
            end
        end
        mst.stop();
        wip[1] = 0;
        chk_wip();
        give_verdict();
    end
endmodule : dual_wiper_i2c_command_decoder_tb_top
